// ===== mfcs_pkg.sv
// constants for the multi-function configuration space decoder
package mfcs_pkg;
	localparam int          CFG_AW      = 11;           // byte address width, eight 256-byte blocks
	localparam int          BLK_LSB     = 8;            // block number starts at this address bit
	localparam int          BLK_W       = 3;            // block number width
	localparam logic [2:0]  BLK_FIRST   = 3'h0;         // block 000h-0ffh
	localparam logic [2:0]  BLK_SECOND  = 3'h1;         // block 100h-1ffh
	localparam logic [2:0]  BLK_THIRD   = 3'h2;         // block 200h-2ffh
	localparam logic [5:0]  HDR_DWORDS  = 6'h10;        // 64-byte standard header, in dwords
	localparam logic [7:0]  OFF_MAKER   = 8'h00;        // maker_code byte offset
	localparam logic [7:0]  OFF_PART    = 8'h02;        // part_code byte offset
	localparam logic [7:0]  OFF_REV     = 8'h08;        // silicon_revision byte offset
	localparam logic [7:0]  OFF_CLASS   = 8'h09;        // function_class byte offset
	localparam logic [7:0]  OFF_HDR     = 8'h0E;        // header_layout byte offset
	localparam logic [23:0] CLASS_RST   = 24'h038000;   // display controller, other, prog if 00
	localparam logic [7:0]  HDR_RST     = 8'h80;        // multi-function, type zero layout
	localparam logic [15:0] MAKER_DFLT  = 16'h1A2B;     // arbitrary value
	localparam logic [15:0] PART_DFLT   = 16'h00C4;     // arbitrary value
	localparam logic [7:0]  REV_DFLT    = 8'h07;        // arbitrary value
	localparam logic [2:0]  FN_NONE     = 3'b000;       // no function selected
	localparam logic [2:0]  FN_INT      = 3'b001;       // internal function
	localparam logic [2:0]  FN_EXT1     = 3'b010;       // external function one
	localparam logic [2:0]  FN_EXT2     = 3'b100;       // external function two
	localparam logic [31:0] DW_ZERO     = 32'h00000000; // zero read value
endpackage

// ===== mfcs_fn_decode.sv
// maps a configuration block number to a function and flags whether it is populated
`timescale 1ns/10ps
module mfcs_fn_decode
	import mfcs_pkg::*;
(
	input  wire logic [2:0] blk,        // address bits 10:8
	input  wire logic       ext1_pres,  // external function one populated
	input  wire logic       ext2_pres,  // external function two populated
	input  wire logic       ext1_vga,   // external function one is vga
	output logic      [2:0] fn_sel,     // one-hot selected function
	output logic            fn_hit      // a populated function is selected
);
	// block to function, swapped order when function one is vga
	always_comb begin
		fn_sel = FN_NONE;
		// one internal, at most two external
		case (blk)
			BLK_FIRST: begin
				fn_sel = ext1_vga ? FN_EXT1 : FN_INT;
			end
			BLK_SECOND: begin
				fn_sel = ext1_vga ? FN_INT : FN_EXT1;
			end
			BLK_THIRD: begin
				fn_sel = FN_EXT2;
			end
			default: begin
				fn_sel = FN_NONE;
			end
		endcase
	end

	always_comb begin
		fn_hit = (fn_sel == FN_INT) || ((fn_sel == FN_EXT1) && ext1_pres) || ((fn_sel == FN_EXT2) && ext2_pres);
	end
endmodule

// ===== mfcs_cfg_space.sv
// configuration space decoder and read-only header of the internal function
`timescale 1ns/10ps
module mfcs_cfg_space
	import mfcs_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE = MAKER_DFLT, // arbitrary value
	parameter logic [15:0] PART_CODE  = PART_DFLT,  // arbitrary value
	parameter logic [7:0]  REVISION   = REV_DFLT    // arbitrary value
)(
	input  wire logic              core_clk,          // primary bus clock
	input  wire logic              rst,               // synchronous reset, high
	input  wire logic              ce,                // clock enable, freezes state when low
	input  wire logic              mode_ext1_present, // mode pin, external function one fitted
	input  wire logic              mode_ext2_present, // mode pin, external function two fitted
	input  wire logic              mode_ext1_vga,     // mode pin, external function one is vga
	input  wire logic              cfg_valid,         // configuration command present, one cycle
	input  wire logic              cfg_write,         // 1 = configuration write, 0 = read
	input  wire logic [CFG_AW-1:0] cfg_addr,          // configuration byte address
	input  wire logic [3:0]        cfg_be_n,          // byte enables, active low
	input  wire logic [31:0]       cfg_wdata,         // write data, read-only space ignores it
	output logic                   cfg_claim,         // command claimed, one-cycle pulse
	output logic [2:0]             cfg_fn_sel,        // one-hot function hit by last command, zero if that command was not claimed
	output logic                   cfg_int_rd,        // last claim was an internal read
	output logic [31:0]            cfg_rdata          // read data of internal function
);
	logic       ext1_r;      // sampled population of ext one
	logic       ext2_r;      // sampled population of ext two
	logic       vga_r;       // sampled vga flag
	logic [2:0] dec_sel;     // decoded function
	logic       dec_hit;     // decoded function populated
	logic [5:0] dw_idx;      // dword index within the block
	logic       cmd_go;      // command taken this cycle
	logic [31:0] rd_nxt;     // read value of the addressed dword

	// header dword lookup, used for the read path only
	function automatic logic [31:0] hdr_dword(input logic [5:0] idx);
		logic [31:0] v;
		v = DW_ZERO;
		if (idx == OFF_MAKER[7:2]) begin
			v = {PART_CODE, MAKER_CODE};
		end else if (idx == OFF_REV[7:2]) begin
			v = {CLASS_RST, REVISION};
		end else if (idx == OFF_HDR[7:2]) begin
			v = {8'h00, HDR_RST, 16'h0000};
		end
		return v;
	endfunction

	// latched only in reset, so a later pin change cannot remap functions
	// mode pins caught during reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ext1_r <= mode_ext1_present;
			ext2_r <= mode_ext2_present;
			vga_r  <= mode_ext1_vga & mode_ext1_present;
		end
	end

	mfcs_fn_decode u_dec (
		.blk       (cfg_addr[CFG_AW-1:BLK_LSB]),
		.ext1_pres (ext1_r),
		.ext2_pres (ext2_r),
		.ext1_vga  (vga_r),
		.fn_sel    (dec_sel),
		.fn_hit    (dec_hit)
	);

	// dword index inside the 256-byte block
	assign dw_idx = cfg_addr[7:2];
	// only configuration commands reach the space
	assign cmd_go = cfg_valid & ce;

	always_comb begin
		rd_nxt = DW_ZERO;
		if (dw_idx < HDR_DWORDS) begin
			rd_nxt = hdr_dword(dw_idx);
		end
	end

	// claim pulse and selected function
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_claim  <= 1'b0;
			cfg_fn_sel <= FN_NONE;
		end else if (ce) begin
			cfg_claim <= cfg_valid & dec_hit;
			if (cfg_valid) begin
				cfg_fn_sel <= dec_hit ? dec_sel : FN_NONE;
			end
		end
	end

	// internal read data, held until the next claim
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_int_rd <= 1'b0;
			cfg_rdata  <= DW_ZERO;
		end else if (ce) begin
			if (cfg_valid & dec_hit) begin
				cfg_int_rd <= (dec_sel == FN_INT) & ~cfg_write;
				cfg_rdata  <= ((dec_sel == FN_INT) & ~cfg_write) ? rd_nxt : DW_ZERO;
			end
		end
	end

	// checks, all on the bus clock and quiet during reset
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// internal read of one dword taken this cycle
	sequence s_int_rd(logic [5:0] i);
		cmd_go && dec_hit && (dec_sel == FN_INT) && !cfg_write && (dw_idx == i);
	endsequence

	// internal write taken this cycle
	sequence s_int_wr;
		cmd_go && (dec_sel == FN_INT) && cfg_write;
	endsequence

	// upper blocks hold no function
	AST_BLOCKS: assert property (cmd_go && (cfg_addr[10:8] > BLK_THIRD)
		|=> !cfg_claim && (cfg_fn_sel == FN_NONE))
		else $error("upper block was claimed");

	// a claim names exactly one function
	AST_ONE_FN: assert property (cfg_claim |-> $onehot(cfg_fn_sel))
		else $error("claim without exactly one function");

	// external hits carry no internal data
	AST_EXT_DATA: assert property (cmd_go && dec_hit && (dec_sel != FN_INT)
		|=> !cfg_int_rd && (cfg_rdata == DW_ZERO))
		else $error("external hit returned internal data");

	// standard order puts internal first
	AST_STD_ORDER: assert property (cmd_go && !vga_r && (cfg_addr[10:8] == BLK_FIRST)
		|=> cfg_claim && (cfg_fn_sel == FN_INT))
		else $error("standard first block not internal");

	// vga order puts internal second
	AST_VGA_SWAP: assert property (cmd_go && vga_r && (cfg_addr[10:8] == BLK_SECOND)
		|=> cfg_claim && (cfg_fn_sel == FN_INT))
		else $error("vga order did not place internal second");

	// vga order puts ext one first
	AST_VGA_FIRST: assert property (cmd_go && vga_r && (cfg_addr[10:8] == BLK_FIRST)
		|=> cfg_claim && (cfg_fn_sel == FN_EXT1))
		else $error("vga order did not place ext one first");

	// absent ext two gets no claim
	AST_EMPTY_EXT2: assert property (cmd_go && !ext2_r && (cfg_addr[10:8] == BLK_THIRD)
		|=> !cfg_claim)
		else $error("absent ext two was claimed");

	// absent ext one gets no claim
	AST_EMPTY_EXT1: assert property (cmd_go && !ext1_r && (cfg_addr[10:8] == BLK_SECOND)
		|=> !cfg_claim && (cfg_fn_sel == FN_NONE))
		else $error("absent ext one was claimed");

	// pins taken at the last reset edge, then held
	AST_MODE_PIN: assert property ($fell(rst)
		|=> (ext1_r == $past(mode_ext1_present, 2)) && (ext2_r == $past(mode_ext2_present, 2)))
		else $error("mode pin not held from reset");

	// device-specific area reads zero
	AST_DEV_ZERO: assert property (cmd_go && dec_hit && (dec_sel == FN_INT) && !cfg_write
		&& (dw_idx >= HDR_DWORDS) |=> cfg_rdata == DW_ZERO)
		else $error("device-specific area not zero");

	// no command, no claim
	AST_IDLE: assert property (ce && !cfg_valid |=> !cfg_claim)
		else $error("claim without a command");

	// identification dword
	AST_IDENT: assert property (s_int_rd(OFF_MAKER[7:2])
		|=> cfg_int_rd && (cfg_rdata == {PART_CODE, MAKER_CODE}))
		else $error("identification dword wrong");

	// class field above revision
	AST_CLASS: assert property (s_int_rd(OFF_CLASS[7:2]) |=> cfg_rdata[31:8] == CLASS_RST)
		else $error("class field wrong");

	// header type byte
	AST_HDR: assert property (s_int_rd(OFF_HDR[7:2]) |=> cfg_rdata[23:16] == HDR_RST)
		else $error("header type wrong");

	// internal write is claimed and returns nothing
	AST_WR_DONE: assert property (s_int_wr
		|=> cfg_claim && !cfg_int_rd && (cfg_rdata == DW_ZERO))
		else $error("internal write not completed");

	// read right after a write still shows the fixed values
	AST_RO_WRITE: assert property (s_int_wr ##1 s_int_rd(OFF_REV[7:2])
		|=> cfg_rdata == {CLASS_RST, REVISION})
		else $error("write changed a read-only field");

	// enable low freezes every output
	AST_FREEZE: assert property (!ce |=> $stable(cfg_claim) && $stable(cfg_fn_sel)
		&& $stable(cfg_int_rd) && $stable(cfg_rdata))
		else $error("outputs moved while enable low");
endmodule

// ===== mfcs_host_model.sv
// host configuration master model for the command port
`timescale 1ns/10ps
module mfcs_host_model (
	input  wire logic   core_clk,  // bus clock
	output logic        cfg_valid, // command strobe
	output logic        cfg_write, // write when high
	output logic [10:0] cfg_addr,  // byte address
	output logic [3:0]  cfg_be_n,  // byte enables, low
	output logic [31:0] cfg_wdata  // write data
);
	// quiet bus at start
	initial begin
		cfg_valid = 1'b0;
		cfg_write = 1'b0;
		cfg_addr  = 11'h000;
		cfg_be_n  = 4'hF;
		cfg_wdata = 32'h00000000;
	end
	task automatic cmd(input logic wr, input logic [10:0] a, input logic [3:0] be, input logic [31:0] d);
		cfg_valid = 1'b1;
		cfg_write = wr;
		cfg_addr  = a;
		cfg_be_n  = be;
		cfg_wdata = d;
		@(posedge core_clk);
		#1;
	endtask
	// released lines show a changing pattern
	task automatic idle();
		cfg_valid = 1'b0;
		cfg_addr  = ~cfg_addr;
		cfg_wdata = ~cfg_wdata;
		@(posedge core_clk);
		#1;
	endtask
endmodule

// ===== testbench.sv
// self-checking bench of the configuration space decoder
`timescale 1ns/10ps
module testbench
	import mfcs_pkg::*;
;
	logic        core_clk, rst, ce, p1, p2, pv;    // clock, reset, enable, mode pins
	logic        cfg_valid, cfg_write, cfg_claim, cfg_int_rd;
	logic [10:0] cfg_addr;                         // command address
	logic [3:0]  cfg_be_n;                         // byte enables
	logic [2:0]  cfg_fn_sel, e_sel;                // seen and expected function
	logic [31:0] cfg_wdata, cfg_rdata, e_dat, seed;
	logic        m1, m2, mv, e_claim, e_rd;        // latched modes, expectations
	int          n_fail, total_checks;
	logic [10:0] corner [11] = '{11'h000, 11'h008, 11'h00C, 11'h03C, 11'h040, 11'h0FC, 11'h100, 11'h108,
		11'h200, 11'h300, 11'h7FC};
	mfcs_host_model host_u (.core_clk(core_clk), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
		.cfg_addr(cfg_addr), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata));
	mfcs_cfg_space dut_u (.core_clk(core_clk), .rst(rst), .ce(ce), .mode_ext1_present(p1),
		.mode_ext2_present(p2), .mode_ext1_vga(pv), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
		.cfg_addr(cfg_addr), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata), .cfg_claim(cfg_claim),
		.cfg_fn_sel(cfg_fn_sel), .cfg_int_rd(cfg_int_rd), .cfg_rdata(cfg_rdata));
	// free-running clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// xorshift step
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [2:0] f_sel(input logic [2:0] b);
		case (b)
			3'h0: return (m1 && mv) ? FN_EXT1 : FN_INT;
			3'h1: return (m1 && mv) ? FN_INT : (m1 ? FN_EXT1 : FN_NONE);
			3'h2: return m2 ? FN_EXT2 : FN_NONE;
			default: return FN_NONE;
		endcase
	endfunction
	function automatic logic [31:0] f_dat(input logic [7:0] o);
		case (o[7:2])
			6'h00: return {PART_DFLT, MAKER_DFLT};
			6'h02: return {CLASS_RST, REV_DFLT};
			6'h03: return {8'h00, HDR_RST, 16'h0000};
			default: return DW_ZERO;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic checks();
		chk(32'(cfg_claim), 32'(e_claim));
		chk(32'(cfg_fn_sel), 32'(e_sel));
		chk(32'(cfg_int_rd), 32'(e_rd));
		chk(cfg_rdata, e_dat);
	endtask
	// one command, ce low means not taken
	task automatic run(input logic wr, input logic [10:0] a, input logic c);
		ce = c;
		host_u.cmd(wr, a, seed[3:0], seed);
		if (c) begin
			e_sel = f_sel(a[10:8]);
			e_claim = |e_sel;
			if (|e_sel) begin
				e_rd = (e_sel === FN_INT) && !wr;
				e_dat = e_rd ? f_dat(a[7:0]) : DW_ZERO;
			end
		end
		checks();
	endtask
	task automatic do_reset();
		rst = 1'b1;
		ce = 1'b1;
		{p1, p2, pv} = {m1, m2, mv};
		host_u.idle();
		repeat (15) @(posedge core_clk);
		#1;
		rst = 1'b0;
		{p1, p2, pv} = ~{m1, m2, mv};
		{e_claim, e_rd, e_sel, e_dat} = '0;
		checks();
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		#200000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		{rst, ce, p1, p2, pv, n_fail, total_checks} = '0;
		seed = 32'hF37A;
		for (int m = 0; m < 8; m++) begin
			{mv, m2, m1} = 3'(m);
			do_reset();
			foreach (corner[i]) run(1'b0, corner[i], 1'b1);
			run(1'b1, 11'h008, 1'b1);
			run(1'b0, 11'h008, 1'b1);
			for (int k = 0; k < 40; k++) begin
				seed = xs(seed);
				run(seed[31], seed[10:0], seed[30:28] != 3'h0);
				if (seed[27:26] == 2'b00) begin
					ce = 1'b1;
					host_u.idle();
					e_claim = 1'b0;
					checks();
				end
			end
			$display("mode %0d done, mismatches %0d", m, n_fail);
		end
		tally_and_finish();
	end
endmodule
